// ---- design/olpr_pkg.sv ----
package olpr_pkg;
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFF_PERIOD_CUR = 8'h1c;
  localparam logic [7:0]  OFF_CTRL_HEAD  = 8'h20;
  localparam logic [7:0]  OFF_CTRL_CUR   = 8'h24;
  localparam int          PTR_LSB        = 4;
  localparam int          PTR_MSB        = 31;
  localparam logic [27:0] PTR_RESET      = 28'h0000000;
  localparam logic [3:0]  RSVD_BITS      = 4'h0;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h00000000;
endpackage

// ---- design/olpr_ptr_reg.sv ----
`timescale 1ns/100ps
// One 16-byte-aligned pointer register, loaded by the list engine
module olpr_ptr_reg (
  input  wire logic        clk_sys,
  input  wire logic        rstSync_n,
  input  wire logic        loadEn,
  input  wire logic [31:0] loadVal,
  output logic      [27:0] ptr_q
);
  import olpr_pkg::*;

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ptr_q <= PTR_RESET;
    end else if (loadEn) begin
      // Low four address bits dropped: descriptors are 16-byte aligned
      ptr_q <= loadVal[PTR_MSB:PTR_LSB];
    end
  end
endmodule

// ---- design/olpr_list_pointer_regs.sv ----
`timescale 1ns/100ps
module olpr_list_pointer_regs (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  rdEn,
  input  wire logic [olpr_pkg::ADDR_W-1:0] rdAddr,
  output logic      [31:0]           rdData_q,
  output logic                       rdValid_q,
  input  wire logic                  periodicDone,
  input  wire logic [31:0]           periodicNextPtr,
  input  wire logic                  hccaInitLoad,
  input  wire logic [31:0]           hccaCtrlHead,
  input  wire logic                  ctrlListStart,
  input  wire logic                  ctrlAdvance,
  input  wire logic [31:0]           ctrlNextPtr,
  output logic      [31:0]           ctrlFetchAddr_q
);
  import olpr_pkg::*;

  logic        rstMeta_q;
  logic        rstSync_n;
  logic [27:0] periodicPtr;
  logic [27:0] ctrlHeadPtr;
  logic [27:0] ctrlCurPtr;
  logic        ctrlCurLoad;
  logic [31:0] ctrlCurVal;

  function automatic logic [31:0] ptr_word(input logic [27:0] p);
    return {p, RSVD_BITS};
  endfunction

  // Reset asserts asynchronously but releases through two flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  olpr_ptr_reg uPeriodic (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .loadEn    (periodicDone),
    .loadVal   (periodicNextPtr),
    .ptr_q     (periodicPtr)
  );

  olpr_ptr_reg uCtrlHead (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .loadEn    (hccaInitLoad),
    .loadVal   (hccaCtrlHead),
    .ptr_q     (ctrlHeadPtr)
  );

  // List start beats advance: a new walk always begins at the head
  assign ctrlCurLoad = ctrlListStart | ctrlAdvance;
  assign ctrlCurVal  = ctrlListStart ? ptr_word(ctrlHeadPtr) : ctrlNextPtr;

  olpr_ptr_reg uCtrlCur (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .loadEn    (ctrlCurLoad),
    .loadVal   (ctrlCurVal),
    .ptr_q     (ctrlCurPtr)
  );

  // Registered so the fetch port sees a flop, never the start/advance mux
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctrlFetchAddr_q <= UNMAPPED_DATA;
    end else if (ctrlListStart) begin
      ctrlFetchAddr_q <= ptr_word(ctrlHeadPtr);
    end else if (ctrlAdvance) begin
      ctrlFetchAddr_q <= {ctrlNextPtr[PTR_MSB:PTR_LSB], RSVD_BITS};
    end
  end

  // Read answers one cycle after rdEn; registers are read-only
  // Unmapped offsets answer zero rather than stall, so software never hangs
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rdData_q  <= UNMAPPED_DATA;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdEn;
      if (rdEn) begin
        if (rdAddr == OFF_PERIOD_CUR) begin
          rdData_q <= ptr_word(periodicPtr);
        end else if (rdAddr == OFF_CTRL_HEAD) begin
          rdData_q <= ptr_word(ctrlHeadPtr);
        end else if (rdAddr == OFF_CTRL_CUR) begin
          rdData_q <= ptr_word(ctrlCurPtr);
        end else begin
          rdData_q <= UNMAPPED_DATA;
        end
      end
    end
  end

  // Pointer stores drop bits 3:0, so the load checks compare the upper field only
  property p_periodic_update;
    @(posedge clk_sys) disable iff (!rstSync_n)
      periodicDone |=> periodicPtr == $past(periodicNextPtr[PTR_MSB:PTR_LSB]);
  endproperty
  a_periodic_update: assert property (p_periodic_update) else $error("periodic pointer not updated");

  property p_periodic_hold;
    @(posedge clk_sys) disable iff (!rstSync_n)
      !periodicDone |=> $stable(periodicPtr);
  endproperty
  a_periodic_hold: assert property (p_periodic_hold) else $error("periodic pointer changed without event");

  property p_read_periodic;
    @(posedge clk_sys) disable iff (!rstSync_n)
      (rdEn && rdAddr == OFF_PERIOD_CUR) |=> rdValid_q && rdData_q == {$past(periodicPtr), RSVD_BITS};
  endproperty
  a_read_periodic: assert property (p_read_periodic) else $error("periodic read wrong");

  property p_read_head;
    @(posedge clk_sys) disable iff (!rstSync_n)
      (rdEn && rdAddr == OFF_CTRL_HEAD) |=> rdData_q == {$past(ctrlHeadPtr), RSVD_BITS};
  endproperty
  a_read_head: assert property (p_read_head) else $error("control head read wrong");

  property p_read_cur;
    @(posedge clk_sys) disable iff (!rstSync_n)
      (rdEn && rdAddr == OFF_CTRL_CUR) |=> rdData_q == {$past(ctrlCurPtr), RSVD_BITS};
  endproperty
  a_read_cur: assert property (p_read_cur) else $error("control current read wrong");

  property p_head_load;
    @(posedge clk_sys) disable iff (!rstSync_n)
      hccaInitLoad |=> ctrlHeadPtr == $past(hccaCtrlHead[PTR_MSB:PTR_LSB]);
  endproperty
  a_head_load: assert property (p_head_load) else $error("head not loaded from HCCA");

  property p_walk_start;
    @(posedge clk_sys) disable iff (!rstSync_n)
      ctrlListStart |=> ctrlFetchAddr_q == {$past(ctrlHeadPtr), RSVD_BITS} && ctrlCurPtr == $past(ctrlHeadPtr);
  endproperty
  a_walk_start: assert property (p_walk_start) else $error("walk did not start at head");

  property p_low_zero;
    @(posedge clk_sys) disable iff (!rstSync_n)
      rdValid_q |-> rdData_q[PTR_LSB-1:0] == RSVD_BITS;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("reserved bits not zero");

  property p_head_hold;
    @(posedge clk_sys) disable iff (!rstSync_n)
      !hccaInitLoad |=> $stable(ctrlHeadPtr);
  endproperty
  a_head_hold: assert property (p_head_hold) else $error("control head changed without init load");

  property p_ctrl_advance;
    @(posedge clk_sys) disable iff (!rstSync_n)
      (ctrlAdvance && !ctrlListStart) |=> ctrlCurPtr == $past(ctrlNextPtr[PTR_MSB:PTR_LSB]);
  endproperty
  a_ctrl_advance: assert property (p_ctrl_advance) else $error("control current not advanced");

  property p_cur_hold;
    @(posedge clk_sys) disable iff (!rstSync_n)
      !(ctrlListStart || ctrlAdvance) |=> $stable(ctrlCurPtr);
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("control current changed without event");

  // Fetch address and current pointer share their load events, so they never diverge
  property p_fetch_tracks_cur;
    @(posedge clk_sys) disable iff (!rstSync_n)
      ctrlFetchAddr_q == {ctrlCurPtr, RSVD_BITS};
  endproperty
  a_fetch_tracks_cur: assert property (p_fetch_tracks_cur) else $error("fetch address differs from current");

  property p_fetch_hold;
    @(posedge clk_sys) disable iff (!rstSync_n)
      !(ctrlListStart || ctrlAdvance) |=> $stable(ctrlFetchAddr_q);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch address changed without event");

  property p_valid_follows;
    @(posedge clk_sys) disable iff (!rstSync_n)
      rdEn |=> rdValid_q;
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("read not answered");

  property p_valid_idle;
    @(posedge clk_sys) disable iff (!rstSync_n)
      !rdEn |=> !rdValid_q;
  endproperty
  a_valid_idle: assert property (p_valid_idle) else $error("read valid without request");

  property p_data_hold;
    @(posedge clk_sys) disable iff (!rstSync_n)
      !rdEn |=> $stable(rdData_q);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data changed without request");

  property p_read_unmapped;
    @(posedge clk_sys) disable iff (!rstSync_n)
      (rdEn && rdAddr != OFF_PERIOD_CUR && rdAddr != OFF_CTRL_HEAD && rdAddr != OFF_CTRL_CUR)
      |=> rdData_q == UNMAPPED_DATA;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_reset_values;
    @(posedge clk_sys) disable iff (!rstSync_n)
      $rose(rstSync_n) |-> periodicPtr == PTR_RESET && ctrlHeadPtr == PTR_RESET
      && ctrlCurPtr == PTR_RESET && !rdValid_q;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("pointers not zero after reset");
endmodule

// ---- testbench/olpr_list_pointer_regs_tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module olpr_list_pointer_regs_tb;
  import olpr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        rdEn = 1'b0;
  logic [7:0]  rdAddr = 8'h00;
  logic [31:0] rdData_q;
  logic        rdValid_q;
  logic [3:0]  evSel = 4'h0;
  logic [31:0] evVal = 32'h00000000;
  logic [31:0] ctrlFetchAddr_q;
  int          fails = 0;
  int          compares = 0;

  olpr_list_pointer_regs dut (
    .clk_sys        (clk_sys),
    .arst_n         (arst_n),
    .rdEn           (rdEn),
    .rdAddr         (rdAddr),
    .rdData_q       (rdData_q),
    .rdValid_q      (rdValid_q),
    .periodicDone   (evSel[0]),
    .periodicNextPtr(evVal),
    .hccaInitLoad   (evSel[1]),
    .hccaCtrlHead   (evVal),
    .ctrlListStart  (evSel[2]),
    .ctrlAdvance    (evSel[3]),
    .ctrlNextPtr    (evVal),
    .ctrlFetchAddr_q(ctrlFetchAddr_q)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Fixed one-cycle answer, so no polling loop is needed
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    rdEn   <= 1'b1;
    rdAddr <= a;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    #1;
    `CHK("rdValid", 1'b1, rdValid_q)
    `CHK("rdData", e, rdData_q)
  endtask

  // One-cycle engine event pulse; low nibble of v is deliberately non-zero in tests
  task automatic ev(input logic [3:0] s, input logic [31:0] v);
    @(posedge clk_sys);
    evSel <= s;
    evVal <= v;
    @(posedge clk_sys);
    evSel <= 4'h0;
    evVal <= ~v;
    #1;
  endtask

  initial begin
    #1000000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(OFF_PERIOD_CUR, 32'h00000000);
    rd(OFF_CTRL_HEAD, 32'h00000000);
    rd(OFF_CTRL_CUR, 32'h00000000);
    rd(8'h28, 32'h00000000);
    `CHK("fetch", 32'h00000000, ctrlFetchAddr_q)
    ev(4'h1, 32'hdeadbeef);
    rd(OFF_PERIOD_CUR, 32'hdeadbee0);
    ev(4'h1, 32'h1234567f);
    `CHK("rdData hold", 32'hdeadbee0, rdData_q)
    `CHK("rdValid idle", 1'b0, rdValid_q)
    rd(OFF_PERIOD_CUR, 32'h12345670);
    ev(4'h1, 32'h0fedcba5);
    rd(OFF_PERIOD_CUR, 32'h0fedcba0);
    rd(OFF_PERIOD_CUR, 32'h0fedcba0);
    ev(4'h2, 32'habcdef0f);
    rd(OFF_CTRL_HEAD, 32'habcdef00);
    rd(OFF_CTRL_HEAD, 32'habcdef00);
    rd(OFF_CTRL_CUR, 32'h00000000);
    ev(4'h4, 32'h55555555);
    `CHK("fetch", 32'habcdef00, ctrlFetchAddr_q)
    rd(OFF_CTRL_CUR, 32'habcdef00);
    ev(4'h8, 32'h0000123b);
    `CHK("fetch", 32'h00001230, ctrlFetchAddr_q)
    rd(OFF_CTRL_CUR, 32'h00001230);
    // Start must win over a same-cycle advance
    ev(4'hc, 32'h99999999);
    `CHK("fetch", 32'habcdef00, ctrlFetchAddr_q)
    rd(OFF_CTRL_CUR, 32'habcdef00);
    rd(OFF_PERIOD_CUR, 32'h0fedcba0);
    // A mid-run reset must clear every loaded pointer
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(OFF_PERIOD_CUR, 32'h00000000);
    rd(OFF_CTRL_HEAD, 32'h00000000);
    rd(OFF_CTRL_CUR, 32'h00000000);
    `CHK("fetch", 32'h00000000, ctrlFetchAddr_q)
    finish_test();
  end
endmodule
